// >>> ubc_core.sv
// ubc_core: firmware-side sequencer issuing one sfr access per command
// assumes: host software drives cmd registers through a plain strobe port
`timescale 1ns/1ps
module ubc_core
  import ubc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  ubc_if.core              sfr,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);
  // cmd word: [15] 1=write 0=read, [14:8] unused, sfr address in cmd[7:0], write data via data reg
  ubc_state_e  state_q;
  logic [7:0]  addr_q;
  logic [7:0]  wdata_q;
  logic        is_wr_q;
  logic [7:0]  rd_q;
  logic        done_q;
  logic        sfr_wr_q;
  logic        sfr_rd_q;

  // command accepted only while idle; otherwise dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= UBC_IDLE;
      addr_q   <= 8'h00;
      wdata_q  <= 8'h00;
      is_wr_q  <= 1'b0;
      sfr_wr_q <= 1'b0;
      sfr_rd_q <= 1'b0;
    end else begin
      sfr_wr_q <= 1'b0;
      sfr_rd_q <= 1'b0;
      unique case (state_q)
        UBC_IDLE: begin
          if (reg_wr && reg_addr == CTL_ADDR_CMD) begin
            addr_q   <= reg_wdata[7:0];
            is_wr_q  <= reg_wdata[15];
            state_q  <= UBC_REQ;
          end else if (reg_wr && reg_addr == CTL_ADDR_DATA) begin
            wdata_q  <= reg_wdata[7:0];
          end
        end
        UBC_REQ: begin
          sfr_wr_q <= is_wr_q;
          sfr_rd_q <= !is_wr_q;
          state_q  <= is_wr_q ? UBC_IDLE : UBC_WAIT;
        end
        // read data stands only in the cycle after the strobe cycle
        UBC_WAIT: state_q <= UBC_CAPT;
        UBC_CAPT: state_q <= UBC_IDLE;
      endcase
    end
  end

  // result capture; set wins over clear of done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      if (state_q == UBC_CAPT) begin
        rd_q   <= sfr.sfr_rdata;
        done_q <= 1'b1;
      end else if (state_q == UBC_REQ && is_wr_q) begin
        done_q <= 1'b1;
      end else if (reg_wr && reg_addr == CTL_ADDR_CMD) begin
        done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CTL_ADDR_STAT: reg_rdata <= {14'h0000, state_q != UBC_IDLE, done_q};
        CTL_ADDR_DATA: reg_rdata <= {8'h00, rd_q};
        default:       reg_rdata <= {is_wr_q, 7'h00, addr_q};
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  assign sfr.sfr_wr    = sfr_wr_q;
  assign sfr.sfr_rd    = sfr_rd_q;
  assign sfr.sfr_addr  = addr_q;
  assign sfr.sfr_wdata = wdata_q;
endmodule : ubc_core

// >>> ubc_dev.sv
// ubc_dev: endpoint select, received byte count (low/high) and per-endpoint fifo reset
// assumes: packet store engine pulses pkt_store with the endpoint and count of each packet
`timescale 1ns/1ps
module ubc_dev
  import ubc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  ubc_if.dev                        sfr,
  input  wire logic                 pkt_store,
  input  wire logic [EP_IDX_W-1:0]  pkt_ep,
  input  wire logic [CNT_W-1:0]     pkt_count,
  output logic      [EP_NUM-1:0]    ep_fifo_reset,
  output logic      [EP_IDX_W-1:0]  selected_endpoint_index
);
  logic [CNT_W-1:0]  count_q [EP_NUM];
  logic [7:0]        fifo_rst_q;
  logic [7:0]        rdata_q;
  logic [CNT_W-1:0]  sel_count;

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] t, input logic wr);
    return wr && (a == t);
  endfunction : is_wr

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selected_endpoint_index <= EP_SEL_RESET;
    end else if (is_wr(sfr.sfr_addr, ADDR_EP_SEL, sfr.sfr_wr)) begin
      selected_endpoint_index <= sfr.sfr_wdata[EP_IDX_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_rst_q <= FIFO_RST_RESET;
    end else if (is_wr(sfr.sfr_addr, ADDR_FIFO_RST, sfr.sfr_wr)) begin
      fifo_rst_q <= {1'b0, sfr.sfr_wdata[EP_NUM-1:0]};
    end
  end

  // reset held while bit is one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_fifo_reset <= '0;
    end else begin
      ep_fifo_reset <= fifo_rst_q[EP_NUM-1:0];
    end
  end

  // captured on packet store; fifo reset clears it, but a store to the same endpoint in that cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < EP_NUM; i++) count_q[i] <= '0;
    end else begin
      for (int i = 0; i < EP_NUM; i++) begin
        if (pkt_store && pkt_ep == EP_IDX_W'(i)) begin
          count_q[i] <= pkt_count;
        end else if (fifo_rst_q[i]) begin
          count_q[i] <= '0;
        end
      end
    end
  end

  always_comb begin
    sel_count = '0;
    if (selected_endpoint_index < EP_IDX_W'(EP_NUM)) begin
      sel_count = count_q[selected_endpoint_index];
    end
  end

  // read data one cycle after strobe; writes to count registers ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (sfr.sfr_rd) begin
      unique case (sfr.sfr_addr)
        ADDR_EP_SEL:   rdata_q <= {5'h00, selected_endpoint_index};
        ADDR_CNT_LOW:  rdata_q <= sel_count[7:0];
        ADDR_CNT_HIGH: rdata_q <= {5'h00, sel_count[CNT_W-1:HIGH_LSB]};
        ADDR_FIFO_RST: rdata_q <= fifo_rst_q;
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign sfr.sfr_rdata = rdata_q;
endmodule : ubc_dev

// >>> ubc_if.sv
// ubc_if: special-function register link between core and usb endpoint bank
// assumes: single clock, read data valid the cycle after sfr_rd
`timescale 1ns/1ps
interface ubc_if;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  modport dev (input sfr_wr, input sfr_rd, input sfr_addr, input sfr_wdata, output sfr_rdata);
  modport core (output sfr_wr, output sfr_rd, output sfr_addr, output sfr_wdata, input sfr_rdata);
endinterface : ubc_if

// >>> ubc_pkg.sv
// ubc_pkg: shared constants for the endpoint byte-count / fifo-reset bank
// assumes: one core clock, 8-bit special-function register space
package ubc_pkg;
  localparam int        EP_NUM       = 7;
  localparam int        EP_IDX_W     = 3;
  localparam int        CNT_W        = 11;
  localparam logic [7:0] ADDR_EP_SEL   = 8'hc7;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'he2;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'he3;
  localparam logic [7:0] ADDR_FIFO_RST = 8'hd5;
  localparam logic [7:0] FIFO_RST_RESET = 8'h00;
  localparam logic [2:0] EP_SEL_RESET   = 3'h0;
  localparam int        HIGH_LSB     = 8;
  // controller-side command/status registers
  localparam logic [1:0] CTL_ADDR_CMD  = 2'h0;
  localparam logic [1:0] CTL_ADDR_STAT = 2'h1;
  localparam logic [1:0] CTL_ADDR_DATA = 2'h2;
  typedef enum logic [1:0] {
    UBC_IDLE = 2'b00,
    UBC_REQ  = 2'b01,
    UBC_WAIT = 2'b11,
    UBC_CAPT = 2'b10
  } ubc_state_e;
endpackage : ubc_pkg

// >>> ubc_sva.sv
// ubc_sva: checks on the sfr link between core and endpoint bank
// assumes: strobes come from ubc_core, read data registered in ubc_dev
`timescale 1ns/1ps
module ubc_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_quiet: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  chk_high_zero: assert property (
    $past(sfr_rd) && $past(sfr_addr) == 8'he3 |-> sfr_rdata[7:3] == 5'h00) else $error("count high reserved set");
  chk_rst_bit7: assert property (
    $past(sfr_rd) && $past(sfr_addr) == 8'hd5 |-> !sfr_rdata[7]) else $error("fifo reset bit7 set");
  chk_sel_width: assert property (
    $past(sfr_rd) && $past(sfr_addr) == 8'hc7 |-> sfr_rdata[7:3] == 5'h00) else $error("select too wide");
  chk_unmapped_zero: assert property (
    $past(sfr_rd) && !($past(sfr_addr) inside {8'hc7, 8'he2, 8'he3, 8'hd5}) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_no_both: assert property (!(sfr_wr && sfr_rd))
    else $error("both strobes");
  chk_access_gap: assert property ((sfr_wr || sfr_rd) |=> !(sfr_wr || sfr_rd) [*2])
    else $error("accesses too close");
  chk_rd_single: assert property (sfr_rd |=> !sfr_wr ##1 !sfr_rd)
    else $error("read strobe repeated");
endmodule : ubc_sva

// >>> usb_endpoint_count_and_fifo_reset_tb.sv
// usb_endpoint_count_and_fifo_reset_tb: core and endpoint bank joined over ubc_if
// assumes: each sfr command is done at most three cycles after it is taken
`timescale 1ns/1ps
module usb_endpoint_count_and_fifo_reset_tb import ubc_pkg::*; ;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pkt_store = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [2:0]  pkt_ep = 3'h0, sel_idx;
  logic [10:0] pkt_count = 11'h000;
  logic [6:0]  fifo_rst;
  logic [7:0]  d;
  logic [15:0] q;
  int          n_mismatch = 0, n_checks = 0;
  ubc_if u_ubc_if();
  ubc_dev u_ubc_dev(.clk, .rst_n, .sfr(u_ubc_if.dev), .pkt_store, .pkt_ep, .pkt_count,
    .ep_fifo_reset(fifo_rst), .selected_endpoint_index(sel_idx));
  ubc_core u_ubc_core(.clk, .rst_n, .sfr(u_ubc_if.core), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  ubc_sva u_ubc_sva(.clk, .rst_n, .sfr_wr(u_ubc_if.sfr_wr), .sfr_rd(u_ubc_if.sfr_rd),
    .sfr_addr(u_ubc_if.sfr_addr), .sfr_rdata(u_ubc_if.sfr_rdata));
  always #5 clk = ~clk;
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rw(logic [1:0] a, logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : rw
  task automatic sfr_w(logic [7:0] a, logic [7:0] v);
    rw(CTL_ADDR_DATA, {8'h00, v});
    rw(CTL_ADDR_CMD, {8'h80, a});
    repeat (4) @(posedge clk);
  endtask : sfr_w
  task automatic rr(logic [1:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rr
  task automatic sfr_r(logic [7:0] a);
    rw(CTL_ADDR_CMD, {8'h00, a});
    repeat (4) @(posedge clk);
    rr(CTL_ADDR_DATA);
    d = q[7:0];
  endtask : sfr_r
  task automatic t_counts;
    logic [2:0]  ep_t [3] = '{3'h2, 3'h5, 3'h7};
    logic [10:0] cn_t [3] = '{11'h5a3, 11'h7ff, 11'h123};
    logic [10:0] ex_t [3] = '{11'h5a3, 11'h7ff, 11'h000};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      pkt_store <= 1'b1;
      pkt_ep    <= ep_t[i];
      pkt_count <= cn_t[i];
      @(posedge clk);
      pkt_store <= 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      sfr_w(ADDR_EP_SEL, {5'h00, ep_t[i]});
      chk("select", sel_idx, ep_t[i]);
      sfr_w(ADDR_CNT_HIGH, 8'h00);
      sfr_r(ADDR_CNT_LOW);
      chk("count low", d, ex_t[i][7:0]);
      sfr_r(ADDR_CNT_HIGH);
      chk("count high", d, {5'h00, ex_t[i][10:8]});
    end
  endtask : t_counts
  task automatic t_fifo;
    sfr_r(ADDR_FIFO_RST);
    chk("fifo reset init", d, FIFO_RST_RESET);
    sfr_w(ADDR_FIFO_RST, 8'h7f);
    chk("fifo held", fifo_rst, 7'h7f);
    sfr_r(ADDR_FIFO_RST);
    chk("fifo reset bits", d, 8'h7f);
    @(posedge clk);
    rr(CTL_ADDR_STAT);
    chk("status done", q, 16'h0001);
    @(posedge clk);
    rr(CTL_ADDR_CMD);
    chk("cmd readback", q, 16'h00d5);
    sfr_w(ADDR_FIFO_RST, 8'h00);
    chk("fifo released", fifo_rst, 7'h00);
    sfr_r(8'h00);
    chk("unmapped", d, 8'h00);
  endtask : t_fifo
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_fifo;
    t_counts;
    // count of endpoint 5 must be gone after its fifo reset
    sfr_w(ADDR_FIFO_RST, 8'h20);
    sfr_w(ADDR_FIFO_RST, 8'h00);
    sfr_w(ADDR_EP_SEL, 8'h05);
    sfr_r(ADDR_CNT_HIGH);
    chk("cleared count", d, 8'h00);
    test_done;
  end
endmodule : usb_endpoint_count_and_fifo_reset_tb
